/* File: cps_ctrl.sv */
// Prefetch hint, miss tracking and streaming store controller
// Behaviour
// - Nontemporal line absent from L2 at prefetch is not written to L2.
// - Nontemporal prefetch miss trains the stream; lines of a stream it trains skip L2.
// - All three level-hint prefetches act as a plain read prefetch.
// - Write-intent prefetch installs its line modified.
// - At most eight outstanding misses, prefetches and loads alike.
// - With all slots busy the next read stalls until one frees.
// - Pending prefetches go to memory in issue order.
// - Streaming stores may pass loads and ordinary stores.
// - Fence holds later ordinary stores until streaming stores are done.
// - Streaming stores bypass the cache via write combining, no allocate.
// - Streaming stores never read memory to fill a line.
// - Ordinary stores to write-combining memory are combined automatically.
// - Two consecutive line misses train a stream issuing initial prefetches.
// - Every software prefetch kind trains the hardware prefetcher.
// - Requests to one line share a single miss slot.
// - All fills, prefetches and evictions use whole 64-byte lines.
`timescale 1ns/1ns
`default_nettype none
module cps_ctrl #(
  parameter int MISS_SLOTS = cps_pkg::MISS_SLOTS,
  parameter int PF_INIT = cps_pkg::PF_INIT
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  // Core request port
  input wire logic req_valid_i,
  input wire cps_pkg::cps_op_t req_op_i,
  input wire logic [cps_pkg::ADDR_W-1:0] req_addr_i,
  input wire logic [cps_pkg::DATA_W-1:0] req_data_i,
  input wire logic req_l1_hit_i,
  input wire logic req_l2_hit_i,
  input wire logic req_wc_type_i,
  output logic req_ready_o,
  // Memory read requests and fills
  output logic mem_rd_valid_o,
  output logic [cps_pkg::LINE_W-1:0] mem_rd_line_o,
  output logic [cps_pkg::SLOT_W-1:0] mem_rd_slot_o,
  output logic mem_rd_excl_o,
  input wire logic fill_valid_i,
  input wire logic [cps_pkg::SLOT_W-1:0] fill_slot_i,
  // Line install into the first level data cache
  output logic inst_valid_o,
  output logic [cps_pkg::LINE_W-1:0] inst_line_o,
  output logic inst_modified_o,
  output logic inst_no_l2_o,
  // Eviction from the first level data cache
  input wire logic evict_valid_i,
  input wire logic [cps_pkg::LINE_W-1:0] evict_line_i,
  input wire logic evict_dirty_i,
  input wire logic evict_no_l2_i,
  output logic l2_wr_valid_o,
  output logic [cps_pkg::LINE_W-1:0] l2_wr_line_o,
  output logic mem_wr_valid_o,
  output logic [cps_pkg::LINE_W-1:0] mem_wr_line_o,
  // Ordinary cached stores
  output logic st_valid_o,
  output logic [cps_pkg::ADDR_W-1:0] st_addr_o,
  output logic [cps_pkg::DATA_W-1:0] st_data_o,
  // Write-combining buffer path
  output logic wc_valid_o,
  output logic [cps_pkg::ADDR_W-1:0] wc_addr_o,
  output logic [cps_pkg::DATA_W-1:0] wc_data_o,
  output logic wc_stream_o,
  input wire logic wc_ack_i,
  // Cache copy invalidation
  output logic inval_valid_o,
  output logic [cps_pkg::LINE_W-1:0] inval_line_o
);
  localparam int LW = cps_pkg::LINE_W;
  localparam int CW = $clog2(MISS_SLOTS + 1);
  localparam int WW = cps_pkg::WC_CNT_W;

  typedef struct packed {
    cps_pkg::cps_miss_t [MISS_SLOTS-1:0] slot;
    logic ready;
    logic rd_vld;
    logic [LW-1:0] rd_line;
    logic [cps_pkg::SLOT_W-1:0] rd_slot;
    logic rd_excl;
    logic inst_vld;
    logic [LW-1:0] inst_line;
    logic inst_mod;
    logic inst_no_l2;
    logic l2_vld;
    logic [LW-1:0] l2_line;
    logic mw_vld;
    logic [LW-1:0] mw_line;
    logic st_vld;
    logic [cps_pkg::ADDR_W-1:0] st_addr;
    logic [cps_pkg::DATA_W-1:0] st_data;
    logic wc_vld;
    logic [cps_pkg::ADDR_W-1:0] wc_addr;
    logic [cps_pkg::DATA_W-1:0] wc_data;
    logic wc_stream;
    logic inv_vld;
    logic [LW-1:0] inv_line;
    logic [WW-1:0] wc_cnt;
    logic fence_wait;
  } cps_ctrl_st_t;

  cps_ctrl_st_t s_ff;
  cps_ctrl_st_t nxt_s;
  cps_pf_if pf_if ();

  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic [LW-1:0] line_of(
    input logic [cps_pkg::ADDR_W-1:0] a);
    line_of = a[cps_pkg::ADDR_W-1:cps_pkg::OFS_W];
  endfunction

  function automatic logic [CW-1:0] busy_count(
    input cps_pkg::cps_miss_t [MISS_SLOTS-1:0] sl);
    busy_count = '0;
    for (int i = 0; i < MISS_SLOTS; i++) begin
      busy_count = busy_count + {{(CW-1){1'b0}}, sl[i].vld};
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Stream prefetcher
  cps_stream_pf #(.PF_INIT(PF_INIT)) u_pf (
    .ref_clk_i(ref_clk_i),
    .rstn_i(rstn_i),
    .pf(pf_if.pf)
  );

  // Outputs straight from state
  assign req_ready_o = s_ff.ready;
  assign mem_rd_valid_o = s_ff.rd_vld;
  assign mem_rd_line_o = s_ff.rd_line;
  assign mem_rd_slot_o = s_ff.rd_slot;
  assign mem_rd_excl_o = s_ff.rd_excl;
  assign inst_valid_o = s_ff.inst_vld;
  assign inst_line_o = s_ff.inst_line;
  assign inst_modified_o = s_ff.inst_mod;
  assign inst_no_l2_o = s_ff.inst_no_l2;
  assign l2_wr_valid_o = s_ff.l2_vld;
  assign l2_wr_line_o = s_ff.l2_line;
  assign mem_wr_valid_o = s_ff.mw_vld;
  assign mem_wr_line_o = s_ff.mw_line;
  assign st_valid_o = s_ff.st_vld;
  assign st_addr_o = s_ff.st_addr;
  assign st_data_o = s_ff.st_data;
  assign wc_valid_o = s_ff.wc_vld;
  assign wc_addr_o = s_ff.wc_addr;
  assign wc_data_o = s_ff.wc_data;
  assign wc_stream_o = s_ff.wc_stream;
  assign inval_valid_o = s_ff.inv_vld;
  assign inval_line_o = s_ff.inv_line;

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    logic take;
    logic is_read;
    logic core_miss;
    logic want;
    logic wr;
    logic nt;
    logic no_l2;
    logic [LW-1:0] line;
    logic hit_any;
    logic [cps_pkg::SLOT_W-1:0] hit_idx;
    logic free_any;
    logic [cps_pkg::SLOT_W-1:0] free_idx;
    logic wc_inc;
    logic fence_take;
    wr = 1'b0;
    nt = 1'b0;
    no_l2 = 1'b0;
    take = req_valid_i && s_ff.ready;
    line = line_of(req_addr_i);
    // Level hints collapse into a plain read prefetch
    is_read = req_op_i inside {cps_pkg::CPS_OP_LOAD, cps_pkg::CPS_OP_PF_READ,
      cps_pkg::CPS_OP_PF_HINT_ZERO, cps_pkg::CPS_OP_PF_HINT_ONE,
      cps_pkg::CPS_OP_PF_HINT_TWO, cps_pkg::CPS_OP_PF_WRITE,
      cps_pkg::CPS_OP_PF_NONTEMPORAL};
    core_miss = take && is_read && !req_l1_hit_i;
    free_any = 1'b0;
    free_idx = '0;
    for (int i = MISS_SLOTS - 1; i >= 0; i--) begin
      if (!s_ff.slot[i].vld) begin
        free_any = 1'b1;
        free_idx = cps_pkg::SLOT_W'(i);
      end
    end
    // Hardware prefetch only fills idle cycles, so core order stays intact
    pf_if.gen_take = pf_if.gen_valid && !core_miss && free_any;
    pf_if.train_valid = core_miss;
    pf_if.train_line = line;
    pf_if.train_nt = req_op_i == cps_pkg::CPS_OP_PF_NONTEMPORAL;
    pf_if.access_valid = take && is_read;
    pf_if.access_line = line;
    want = core_miss || pf_if.gen_take;
    if (core_miss) begin
      wr = req_op_i == cps_pkg::CPS_OP_PF_WRITE;
      nt = req_op_i == cps_pkg::CPS_OP_PF_NONTEMPORAL;
      no_l2 = nt && !req_l2_hit_i;
    end else begin
      line = pf_if.gen_line;
      wr = 1'b0;
      nt = pf_if.gen_nt;
      no_l2 = pf_if.gen_nt;
    end
    // Slot being freed this cycle is not merged into
    hit_any = 1'b0;
    hit_idx = '0;
    for (int i = 0; i < MISS_SLOTS; i++) begin
      if (s_ff.slot[i].vld && s_ff.slot[i].line == line &&
          !(fill_valid_i && fill_slot_i == cps_pkg::SLOT_W'(i))) begin
        hit_any = 1'b1;
        hit_idx = cps_pkg::SLOT_W'(i);
      end
    end
    nxt_s = s_ff;
    nxt_s.rd_vld = 1'b0;
    nxt_s.inst_vld = 1'b0;
    nxt_s.l2_vld = 1'b0;
    nxt_s.mw_vld = 1'b0;
    nxt_s.st_vld = 1'b0;
    nxt_s.wc_vld = 1'b0;
    nxt_s.inv_vld = 1'b0;
    // Fill completes: install whole line and release its slot
    if (fill_valid_i) begin
      nxt_s.inst_vld = 1'b1;
      nxt_s.inst_line = s_ff.slot[fill_slot_i].line;
      nxt_s.inst_mod = s_ff.slot[fill_slot_i].modify;
      nxt_s.inst_no_l2 = s_ff.slot[fill_slot_i].no_l2;
      nxt_s.slot[fill_slot_i].vld = 1'b0;
    end
    // Merge into a live slot or allocate and read in issue order
    if (want && hit_any) begin
      nxt_s.slot[hit_idx].modify = s_ff.slot[hit_idx].modify | wr;
    end else if (want) begin
      nxt_s.slot[free_idx] = '{vld: 1'b1, line: line, modify: wr,
                               no_l2: no_l2};
      nxt_s.rd_vld = 1'b1;
      nxt_s.rd_line = line;
      nxt_s.rd_slot = free_idx;
      nxt_s.rd_excl = wr;
    end
    // Eviction: untouched-by-L2 nontemporal lines skip L2; only dirty ones go back to memory
    if (evict_valid_i) begin
      if (!evict_no_l2_i) begin
        nxt_s.l2_vld = 1'b1;
        nxt_s.l2_line = evict_line_i;
      end else if (evict_dirty_i) begin
        nxt_s.mw_vld = 1'b1;
        nxt_s.mw_line = evict_line_i;
      end
    end
    // Stores: streaming never allocates nor reads memory
    wc_inc = 1'b0;
    fence_take = take && req_op_i == cps_pkg::CPS_OP_STORE_FENCE;
    if (take && req_op_i == cps_pkg::CPS_OP_STREAM_STORE) begin
      wc_inc = 1'b1;
      nxt_s.wc_vld = 1'b1;
      nxt_s.wc_addr = req_addr_i;
      nxt_s.wc_data = req_data_i;
      nxt_s.wc_stream = 1'b1;
      nxt_s.inv_vld = req_l1_hit_i;
      nxt_s.inv_line = line_of(req_addr_i);
    end else if (take && req_op_i == cps_pkg::CPS_OP_STORE) begin
      if (req_wc_type_i) begin
        nxt_s.wc_vld = 1'b1;
        nxt_s.wc_addr = req_addr_i;
        nxt_s.wc_data = req_data_i;
        nxt_s.wc_stream = 1'b0;
      end else begin
        nxt_s.st_vld = 1'b1;
        nxt_s.st_addr = req_addr_i;
        nxt_s.st_data = req_data_i;
      end
    end
    nxt_s.wc_cnt = s_ff.wc_cnt + {{(WW-1){1'b0}}, wc_inc}
                   - {{(WW-1){1'b0}}, wc_ack_i && s_ff.wc_cnt != '0};
    // Fence holds the core until all streaming stores are acknowledged
    nxt_s.fence_wait = (fence_take || s_ff.fence_wait) &&
                       nxt_s.wc_cnt != '0;
    // Conservative ready keeps a slot and counter headroom for next request
    nxt_s.ready = busy_count(nxt_s.slot) < CW'(MISS_SLOTS) &&
                  !nxt_s.fence_wait && !(&nxt_s.wc_cnt);
  end

  // State register
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end
endmodule // cps_ctrl
`default_nettype wire

/* File: cps_ctrl_assertions.sv */
// Port-level checker for the prefetch and streaming store controller
`timescale 1ns/1ns
`default_nettype none
module cps_chk #(
  parameter int MISS_SLOTS = cps_pkg::MISS_SLOTS
) (
  // Clock, reset and core port
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic req_valid_i,
  input wire cps_pkg::cps_op_t req_op_i,
  input wire logic [cps_pkg::ADDR_W-1:0] req_addr_i,
  input wire logic req_l1_hit_i,
  input wire logic req_wc_type_i,
  input wire logic req_ready_o,
  // Miss, install and eviction side
  input wire logic mem_rd_valid_o,
  input wire logic mem_rd_excl_o,
  input wire logic fill_valid_i,
  input wire logic inst_valid_o,
  input wire logic evict_valid_i,
  input wire logic [cps_pkg::LINE_W-1:0] evict_line_i,
  input wire logic evict_no_l2_i,
  input wire logic l2_wr_valid_o,
  input wire logic [cps_pkg::LINE_W-1:0] l2_wr_line_o,
  // Store side
  input wire logic wc_valid_o,
  input wire logic wc_stream_o,
  input wire logic wc_ack_i,
  input wire logic inval_valid_o,
  input wire logic [cps_pkg::LINE_W-1:0] inval_line_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);
  logic tk;
  logic [cps_pkg::LINE_W-1:0] rl;
  int occ;
  int ss;
  assign tk = req_valid_i && req_ready_o;
  assign rl = req_addr_i[cps_pkg::ADDR_W-1:cps_pkg::OFS_W];
  ////////////////
  // Slots and streaming stores in flight, seen from the ports only
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      occ <= 0;
      ss <= 0;
    end else begin
      occ <= occ + int'(mem_rd_valid_o) - int'(fill_valid_i);
      ss <= ss + int'(wc_valid_o && wc_stream_o) - int'(wc_ack_i && ss > 0);
    end
  end
  ////////////////
  a_stream_to_wc: assert property (tk && req_op_i == cps_pkg::CPS_OP_STREAM_STORE
    |=> wc_valid_o && wc_stream_o) else $error("stream store missed wc path");
  a_stream_inval_copy: assert property (tk && req_l1_hit_i &&
    req_op_i == cps_pkg::CPS_OP_STREAM_STORE
    |=> inval_valid_o && inval_line_o == $past(rl)) else $error("no invalidate");
  a_wc_type_store: assert property (tk && req_wc_type_i &&
    req_op_i == cps_pkg::CPS_OP_STORE |=> wc_valid_o && !wc_stream_o)
    else $error("wc type store not combined");
  a_hint_plain_read: assert property (tk && !req_l1_hit_i && req_op_i inside
    {cps_pkg::CPS_OP_PF_HINT_ZERO, cps_pkg::CPS_OP_PF_HINT_ONE,
     cps_pkg::CPS_OP_PF_HINT_TWO} |=> !(mem_rd_valid_o && mem_rd_excl_o))
    else $error("hint prefetch asked write intent");
  a_evict_nt_skip: assert property (evict_valid_i && evict_no_l2_i
    |=> !l2_wr_valid_o) else $error("nontemporal victim written to L2");
  a_evict_to_l2: assert property (evict_valid_i && !evict_no_l2_i
    |=> l2_wr_valid_o && l2_wr_line_o == $past(evict_line_i))
    else $error("victim not written to L2");
  a_fill_installs: assert property (fill_valid_i |=> inst_valid_o)
    else $error("fill without install");
  a_full_stall: assert property (occ >= MISS_SLOTS |-> !req_ready_o)
    else $error("ready with all slots busy");
  a_slot_limit: assert property (occ <= MISS_SLOTS)
    else $error("too many outstanding misses");
  a_fence_stall: assert property (tk && !wc_ack_i &&
    req_op_i == cps_pkg::CPS_OP_STORE_FENCE && (ss > 0 || (wc_valid_o &&
    wc_stream_o)) |=> !req_ready_o) else $error("fence did not stall");
  c_full: cover property (occ == MISS_SLOTS);
  c_inval: cover property (inval_valid_o);
  c_fence: cover property (tk && req_op_i == cps_pkg::CPS_OP_STORE_FENCE);
endmodule // cps_chk
bind cps_ctrl cps_chk #(.MISS_SLOTS(MISS_SLOTS)) u_chk (.*);
`default_nettype wire

/* File: cps_ctrl_tb.sv */
// Self-checking bench for the prefetch and streaming store controller
`timescale 1ns/1ns
`default_nettype none
module cps_ctrl_tb;
  localparam int LW = cps_pkg::LINE_W;
  logic ref_clk_i, rstn_i, req_valid_i, req_l1_hit_i, req_l2_hit_i, hold;
  logic req_wc_type_i, req_ready_o, mem_rd_valid_o, mem_rd_excl_o;
  cps_pkg::cps_op_t req_op_i;
  logic [cps_pkg::ADDR_W-1:0] req_addr_i, st_addr_o, wc_addr_o;
  logic [cps_pkg::DATA_W-1:0] req_data_i, st_data_o, wc_data_o;
  logic [LW-1:0] mem_rd_line_o, inst_line_o, evict_line_i, l2_wr_line_o;
  logic [LW-1:0] mem_wr_line_o, inval_line_o;
  logic [cps_pkg::SLOT_W-1:0] mem_rd_slot_o, fill_slot_i;
  logic fill_valid_i, inst_valid_o, inst_modified_o, inst_no_l2_o;
  logic evict_valid_i, evict_dirty_i, evict_no_l2_i, l2_wr_valid_o;
  logic mem_wr_valid_o, st_valid_o, wc_valid_o, wc_stream_o, wc_ack_i;
  logic inval_valid_o;
  int failures, num_checks, cyc, n_nt, n_st;
  logic [LW-1:0] rd_q[$];
  cps_ctrl dut (.*);
  cps_mem_model u_mem (.ref_clk_i, .rstn_i, .rd_valid_i(mem_rd_valid_o),
    .rd_slot_i(mem_rd_slot_o), .wc_valid_i(wc_valid_o),
    .wc_stream_i(wc_stream_o), .hold_i(hold), .fill_valid_o(fill_valid_i),
    .fill_slot_o(fill_slot_i), .ack_o(wc_ack_i));
  ////////////////
  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end
  // Tally design events between edges; cut a hang short
  always @(negedge ref_clk_i) begin
    if (mem_rd_valid_o === 1'b1) rd_q.push_back(mem_rd_line_o);
    if (inst_valid_o === 1'b1 && inst_no_l2_o === 1'b1) n_nt++;
    if (st_valid_o === 1'b1) n_st++;
  end
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      results();
    end
  end
  ////////////////
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One request, held until ready; returns where its answer stands
  task automatic issue(input cps_pkg::cps_op_t op, input logic [LW-1:0] ln,
                       input logic l1, input logic l2, input logic wc);
    int n;
    @(negedge ref_clk_i);
    req_valid_i = 1'b1;
    req_op_i = op;
    req_addr_i = {ln, 6'h28};
    req_data_i = {16'ha5a5, ln, 6'h28};
    {req_l1_hit_i, req_l2_hit_i, req_wc_type_i} = {l1, l2, wc};
    for (n = 0; n < 400 && req_ready_o !== 1'b1; n++) @(negedge ref_clk_i);
    @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    req_valid_i = 1'b0;
  endtask
  task automatic wait_inst();
    for (int n = 0; n < 100 && inst_valid_o !== 1'b1; n++) begin
      @(negedge ref_clk_i);
    end
  endtask
  task automatic t_pf(input cps_pkg::cps_op_t op, input logic [LW-1:0] ln,
                      input logic l2, input logic ex, input logic nt);
    issue(op, ln, 1'b0, l2, 1'b0);
    chk(mem_rd_valid_o, 1'b1);
    chk(mem_rd_line_o, ln);
    chk(mem_rd_excl_o, ex);
    wait_inst();
    chk(inst_line_o, ln);
    chk(inst_modified_o, ex);
    chk(inst_no_l2_o, nt);
  endtask
  ////////////////
  task automatic test_prefetch();
    cps_pkg::cps_op_t ops[4];
    ops = '{cps_pkg::CPS_OP_PF_READ, cps_pkg::CPS_OP_PF_HINT_ZERO,
            cps_pkg::CPS_OP_PF_HINT_ONE, cps_pkg::CPS_OP_PF_HINT_TWO};
    for (int i = 0; i < 4; i++) t_pf(ops[i], 'h200 + i * 16, 0, 0, 0);
    t_pf(cps_pkg::CPS_OP_PF_WRITE, 'h300, 0, 1, 0);
    t_pf(cps_pkg::CPS_OP_PF_NONTEMPORAL, 'h320, 0, 0, 1);
    t_pf(cps_pkg::CPS_OP_PF_NONTEMPORAL, 'h340, 1, 0, 0);
  endtask
  task automatic test_evict();
    for (int i = 0; i < 2; i++) begin
      @(negedge ref_clk_i);
      {evict_valid_i, evict_dirty_i, evict_no_l2_i} = {2'b11, i[0]};
      evict_line_i = 'h500 + i;
      @(negedge ref_clk_i);
      evict_valid_i = 1'b0;
      chk(l2_wr_valid_o, !i[0]);
      chk(mem_wr_valid_o, i[0]);
    end
    chk(l2_wr_line_o, 'h500);
  endtask
  task automatic test_stores();
    issue(cps_pkg::CPS_OP_STREAM_STORE, 'h900, 1, 0, 0);
    chk({wc_valid_o, wc_stream_o}, 2'b11);
    chk(mem_rd_valid_o, 1'b0);
    chk({inval_valid_o, inval_line_o}, {1'b1, LW'('h900)});
    issue(cps_pkg::CPS_OP_STORE, 'h910, 1, 0, 1);
    chk({wc_valid_o, wc_stream_o, st_valid_o}, 3'b100);
    issue(cps_pkg::CPS_OP_STORE, 'h920, 1, 0, 0);
    chk(st_valid_o, 1'b1);
    chk(st_data_o, {16'ha5a5, LW'('h920), 6'h28});
  endtask
  task automatic test_fence();
    int s;
    hold = 1'b1;
    issue(cps_pkg::CPS_OP_STREAM_STORE, 'ha00, 0, 0, 0);
    issue(cps_pkg::CPS_OP_STORE_FENCE, 'ha10, 0, 0, 0);
    chk(req_ready_o, 1'b0);
    s = n_st;
    fork
      issue(cps_pkg::CPS_OP_STORE, 'ha20, 1, 0, 0);
      begin
        repeat (6) @(negedge ref_clk_i);
        chk(n_st - s, 0);
        hold = 1'b0;
      end
    join
    chk(st_valid_o, 1'b1);
  endtask
  task automatic test_full();
    hold = 1'b1;
    for (int i = 0; i < 8; i++) begin
      issue(cps_pkg::CPS_OP_LOAD, 'h600 + i * 16, 0, 0, 0);
      chk(mem_rd_valid_o, 1'b1);
      if (i == 3) issue(cps_pkg::CPS_OP_PF_READ, 'h600, 0, 0, 0);
      if (i == 3) chk(mem_rd_valid_o, 1'b0);
    end
    chk(req_ready_o, 1'b0);
    repeat (5) @(negedge ref_clk_i);
    chk(req_ready_o, 1'b0);
    hold = 1'b0;
    issue(cps_pkg::CPS_OP_LOAD, 'h700, 0, 0, 0);
    chk(mem_rd_line_o, 'h700);
  endtask
  // Two nontemporal misses on adjacent lines start a tagged stream
  task automatic test_stream();
    int s;
    repeat (60) @(negedge ref_clk_i);
    rd_q.delete();
    s = n_nt;
    issue(cps_pkg::CPS_OP_PF_NONTEMPORAL, 'h800, 0, 0, 0);
    issue(cps_pkg::CPS_OP_PF_NONTEMPORAL, 'h801, 0, 0, 0);
    repeat (60) @(negedge ref_clk_i);
    chk(rd_q.size(), 2 + cps_pkg::PF_INIT);
    for (int i = 0; i < 5; i++) chk(rd_q[i], 'h800 + i);
    chk(n_nt - s, 2 + cps_pkg::PF_INIT);
  endtask
  ////////////////
  task automatic results();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    {req_valid_i, req_addr_i, req_data_i, req_l1_hit_i, req_l2_hit_i} = '0;
    {req_wc_type_i, evict_valid_i, evict_line_i, evict_dirty_i} = '0;
    {evict_no_l2_i, hold, rstn_i} = '0;
    req_op_i = cps_pkg::CPS_OP_LOAD;
    repeat (4) @(negedge ref_clk_i);
    rstn_i = 1'b1;
    test_prefetch();
    test_evict();
    test_stores();
    test_fence();
    test_full();
    test_stream();
    results();
  end
endmodule // cps_ctrl_tb
`default_nettype wire

/* File: cps_mem_model.sv */
// Memory and write-combining partner answering the controller
`timescale 1ns/1ns
`default_nettype none
module cps_mem_model (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  // Requests from the controller, and a stall knob
  input wire logic rd_valid_i,
  input wire logic [cps_pkg::SLOT_W-1:0] rd_slot_i,
  input wire logic wc_valid_i,
  input wire logic wc_stream_i,
  input wire logic hold_i,
  // Answers
  output logic fill_valid_o,
  output logic [cps_pkg::SLOT_W-1:0] fill_slot_o,
  output logic ack_o
);
  logic [cps_pkg::SLOT_W-1:0] q[$];
  int pend;
  int age;
  initial begin
    {fill_valid_o, fill_slot_o, ack_o} = '0;
    pend = 0;
    age = 0;
  end
  // Capture requests; fills come back in issue order, a slot named once
  always @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      q.delete();
      pend = 0;
    end else begin
      if (rd_valid_i === 1'b1) q.push_back(rd_slot_i);
      if (wc_valid_i === 1'b1 && wc_stream_i === 1'b1) pend++;
    end
  end
  // Answer off the sampling edge; idle slot lines toggle, not hold
  always @(negedge ref_clk_i) begin
    fill_valid_o <= 1'b0;
    fill_slot_o <= ~fill_slot_o;
    ack_o <= 1'b0;
    age++;
    if (rstn_i && !hold_i && q.size() > 0 && age > 2) begin
      fill_valid_o <= 1'b1;
      fill_slot_o <= q.pop_front();
      age = 0;
    end
    if (rstn_i && !hold_i && pend > 0) begin
      ack_o <= 1'b1;
      pend--;
    end
  end
endmodule // cps_mem_model
`default_nettype wire

/* File: cps_pf_if.sv */
// Link between the miss controller and the stream prefetcher
`timescale 1ns/1ns
`default_nettype none
interface cps_pf_if;
  logic train_valid;
  logic [cps_pkg::LINE_W-1:0] train_line;
  logic train_nt;
  logic access_valid;
  logic [cps_pkg::LINE_W-1:0] access_line;
  logic gen_valid;
  logic [cps_pkg::LINE_W-1:0] gen_line;
  logic gen_nt;
  logic gen_take;
  modport ctrl (output train_valid, train_line, train_nt, access_valid,
                access_line, gen_take, input gen_valid, gen_line, gen_nt);
  modport pf (input train_valid, train_line, train_nt, access_valid,
              access_line, gen_take, output gen_valid, gen_line, gen_nt);
endinterface
`default_nettype wire

/* File: cps_pkg.sv */
// Shared constants and types for the prefetch and streaming store control
package cps_pkg;
  // Line geometry: every fill, prefetch and eviction moves one whole line
  localparam int LINE_BYTES = 64;
  localparam int OFS_W = $clog2(LINE_BYTES);
  localparam int ADDR_W = 48;
  localparam int LINE_W = ADDR_W - OFS_W;
  localparam int DATA_W = 64;
  // Outstanding miss limit and its index width
  localparam int MISS_SLOTS = 8;
  localparam int SLOT_W = $clog2(MISS_SLOTS);
  // Initial prefetches issued when a stream trains
  localparam int PF_INIT = 3;
  localparam int PF_CNT_W = 4;
  // Width of the outstanding streaming store counter
  localparam int WC_CNT_W = 4;

  // Core request kinds
  typedef enum logic [3:0] {
    CPS_OP_LOAD,
    CPS_OP_STORE,
    CPS_OP_PF_READ,
    CPS_OP_PF_HINT_ZERO,
    CPS_OP_PF_HINT_ONE,
    CPS_OP_PF_HINT_TWO,
    CPS_OP_PF_WRITE,
    CPS_OP_PF_NONTEMPORAL,
    CPS_OP_STREAM_STORE,
    CPS_OP_STORE_FENCE
  } cps_op_t;

  // One miss-tracking slot
  typedef struct packed {
    logic vld;
    logic [LINE_W-1:0] line;
    logic modify;
    logic no_l2;
  } cps_miss_t;
endpackage

/* File: cps_stream_pf.sv */
// Unit-stride hardware stream prefetcher, single stream
`timescale 1ns/1ns
`default_nettype none
module cps_stream_pf #(
  parameter int PF_INIT = cps_pkg::PF_INIT
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  // Controller side
  cps_pf_if.pf pf
);
  typedef struct packed {
    logic last_vld;
    logic [cps_pkg::LINE_W-1:0] last_line;
    logic [cps_pkg::LINE_W-1:0] next_line;
    logic [cps_pkg::LINE_W-1:0] expect_line;
    logic [cps_pkg::PF_CNT_W-1:0] remain;
    logic active;
    logic nt;
  } cps_pf_st_t;

  cps_pf_st_t s_ff;
  cps_pf_st_t nxt_s;

  ////////////////////////////////////////////////////////////////////////////
  // Generated requests come straight from state
  assign pf.gen_valid = s_ff.remain != '0;
  assign pf.gen_line = s_ff.next_line;
  assign pf.gen_nt = s_ff.nt;

  ////////////////////////////////////////////////////////////////////////////
  // Train on misses, propagate on any read access to the expected line
  always_comb begin
    logic inc;
    logic dec;
    inc = 1'b0;
    dec = pf.gen_take && (s_ff.remain != '0);
    nxt_s = s_ff;
    if (dec) begin
      nxt_s.next_line = s_ff.next_line + 1'b1;
    end
    if (pf.access_valid && s_ff.active &&
        pf.access_line == s_ff.expect_line) begin
      inc = 1'b1;
      nxt_s.expect_line = s_ff.expect_line + 1'b1;
    end
    nxt_s.remain = s_ff.remain + {{(cps_pkg::PF_CNT_W-1){1'b0}}, inc}
                   - {{(cps_pkg::PF_CNT_W-1){1'b0}}, dec};
    if (pf.train_valid) begin
      nxt_s.last_vld = 1'b1;
      nxt_s.last_line = pf.train_line;
      // Two consecutive line misses start a fresh stream
      if (s_ff.last_vld && pf.train_line == s_ff.last_line + 1'b1) begin
        nxt_s.active = 1'b1;
        nxt_s.next_line = pf.train_line + 1'b1;
        nxt_s.expect_line = pf.train_line + 1'b1;
        nxt_s.remain = cps_pkg::PF_CNT_W'(PF_INIT);
        nxt_s.nt = pf.train_nt;
      end
    end
  end

  // State register
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end
endmodule // cps_stream_pf
`default_nettype wire
